// >>> rtl/dlm_pkg.sv
// constants for the data lane mirror configuration block
package dlm_pkg;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_MIRRORED = 8'h0E;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_HARD_RESET = 8'hFD;
  localparam logic MIRROR_RESET = 1'b0;
  localparam logic PARALLEL_INIT_RESET = 1'b0;
  localparam logic SEQUENTIAL_INIT_RESET = 1'b0;
  typedef enum logic [1:0] {DLM_UNSET, DLM_NORMAL, DLM_MIRRORED} dlm_mode_t;
endpackage : dlm_pkg

// >>> rtl/dlm_lane_if.sv
// lane swap control carried between the decoder and the lane swapper
`timescale 1ns/1ps
`default_nettype none
interface dlm_lane_if;
  logic mirror;
  modport ctrl (output mirror);
  modport swap (input mirror);
endinterface : dlm_lane_if
`default_nettype wire

// >>> rtl/dlm_lane_swap.sv
// bit-reversing lane swapper for both data directions
`timescale 1ns/1ps
`default_nettype none
module dlm_lane_swap (
  dlm_lane_if.swap lanes,
  input wire logic [7:0] i_ext_in,
  input wire logic [7:0] i_int_out,
  output logic [7:0] o_int_in,
  output logic [7:0] o_ext_out
);
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_lane
      // external lane g maps to internal bit 7-g when mirrored
      assign o_int_in[g] = lanes.mirror ? i_ext_in[7-g] : i_ext_in[g];
      assign o_ext_out[g] = lanes.mirror ? i_int_out[7-g] : i_int_out[g];
    end
  endgenerate
endmodule : dlm_lane_swap
`default_nettype wire

// >>> rtl/dlm_mirror_cfg.sv
// data lane mirror decision, lock and volume init mode selection
// Function
// - mirroring touches only the eight data lanes, other signals stay fixed
// - non-mirrored lanes are used until a configuring command is decoded
// - the first command after initialization decides the lane configuration
// - byte 0Eh is read status and switches the target to mirrored mode
// - mirrored mode holds until power is removed
// - pin reduction and status before first reset selects sequential init
// - pin reduction and status after first reset selects parallel init
// - hard reset leaves the established mirror configuration unchanged
`timescale 1ns/1ps
`default_nettype none
module dlm_mirror_cfg (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_dq_in,
  input wire logic [7:0] i_dq_out_int,
  input wire logic i_pin_reduction_en,
  output logic [7:0] o_dq_in_int,
  output logic [7:0] o_dq_out,
  output logic o_cmd_valid_int,
  output logic o_mirrored,
  output logic o_mode_locked,
  output logic o_sequential_init,
  output logic o_parallel_init
);
  typedef enum logic [1:0] {
    DLM_CMD_OTHER,
    DLM_CMD_STATUS,
    DLM_CMD_STATUS_REV,
    DLM_CMD_RESET
  } dlm_cmd_kind_t;

  dlm_pkg::dlm_mode_t mode_ff;
  dlm_pkg::dlm_mode_t nxt_mode;
  logic mirrored_ff;
  logic nxt_mirrored;
  logic locked_ff;
  logic nxt_locked;
  logic first_reset_seen_ff;
  logic nxt_first_reset_seen;
  logic seq_init_ff;
  logic nxt_seq_init;
  logic par_init_ff;
  logic nxt_par_init;
  dlm_cmd_kind_t raw_kind;
  dlm_cmd_kind_t int_kind;
  logic cmd_first;
  logic cmd_mirrored_first;
  logic cmd_status;
  logic cmd_reset;
  logic init_open;
  logic init_request;
  dlm_lane_if lanes ();

  // i_srst is power-down clear only; the hard reset command never reaches it

  // raw pin byte: status is recognised in either lane order
  always_comb begin
    raw_kind = DLM_CMD_OTHER;
    if (i_cmd_valid) begin
      unique case (i_dq_in)
        dlm_pkg::CMD_STATUS: begin
          raw_kind = DLM_CMD_STATUS;
        end
        dlm_pkg::CMD_STATUS_MIRRORED: begin
          raw_kind = DLM_CMD_STATUS_REV;
        end
        default: begin
          raw_kind = DLM_CMD_OTHER;
        end
      endcase
    end
  end

  // lane-mapped byte: reset reads the same in both lane orders
  always_comb begin
    int_kind = DLM_CMD_OTHER;
    if (i_cmd_valid) begin
      unique case (o_dq_in_int)
        dlm_pkg::CMD_RESET: begin
          int_kind = DLM_CMD_RESET;
        end
        default: begin
          int_kind = DLM_CMD_OTHER;
        end
      endcase
    end
  end

  assign cmd_first = i_cmd_valid && (mode_ff == dlm_pkg::DLM_UNSET);
  assign cmd_mirrored_first = cmd_first && (raw_kind == DLM_CMD_STATUS_REV);
  assign cmd_status = (raw_kind == DLM_CMD_STATUS) || (raw_kind == DLM_CMD_STATUS_REV);
  assign cmd_reset = (int_kind == DLM_CMD_RESET);
  assign init_open = !seq_init_ff && !par_init_ff;
  assign init_request = cmd_status && i_pin_reduction_en && init_open;

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      dlm_pkg::DLM_UNSET: begin
        if (cmd_mirrored_first) begin
          nxt_mode = dlm_pkg::DLM_MIRRORED;
        end else if (cmd_first) begin
          nxt_mode = dlm_pkg::DLM_NORMAL;
        end
      end
      dlm_pkg::DLM_NORMAL: begin
        nxt_mode = dlm_pkg::DLM_NORMAL;
      end
      dlm_pkg::DLM_MIRRORED: begin
        // hard reset and later status bytes leave the mirrored lanes in place
        nxt_mode = dlm_pkg::DLM_MIRRORED;
      end
      default: begin
        nxt_mode = dlm_pkg::DLM_UNSET;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mode_ff <= dlm_pkg::DLM_UNSET;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  assign nxt_mirrored = (nxt_mode == dlm_pkg::DLM_MIRRORED);
  assign nxt_locked = (nxt_mode != dlm_pkg::DLM_UNSET);

  // status outputs come straight from flops
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mirrored_ff <= dlm_pkg::MIRROR_RESET;
    end else begin
      mirrored_ff <= nxt_mirrored;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      locked_ff <= 1'b0;
    end else begin
      locked_ff <= nxt_locked;
    end
  end

  always_comb begin
    nxt_first_reset_seen = first_reset_seen_ff;
    if (cmd_reset) begin
      nxt_first_reset_seen = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      first_reset_seen_ff <= 1'b0;
    end else begin
      first_reset_seen_ff <= nxt_first_reset_seen;
    end
  end

  // init order is decided once by the first status seen with pin reduction on
  always_comb begin
    nxt_seq_init = seq_init_ff;
    if (init_request && !first_reset_seen_ff) begin
      nxt_seq_init = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      seq_init_ff <= dlm_pkg::SEQUENTIAL_INIT_RESET;
    end else begin
      seq_init_ff <= nxt_seq_init;
    end
  end

  always_comb begin
    nxt_par_init = par_init_ff;
    if (init_request && first_reset_seen_ff) begin
      nxt_par_init = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      par_init_ff <= dlm_pkg::PARALLEL_INIT_RESET;
    end else begin
      par_init_ff <= nxt_par_init;
    end
  end

  // undecided mode uses straight lanes
  assign lanes.mirror = mirrored_ff;

  // only data lanes pass through the swapper
  dlm_lane_swap u_swap (
    .lanes(lanes),
    .i_ext_in(i_dq_in),
    .i_int_out(i_dq_out_int),
    .o_int_in(o_dq_in_int),
    .o_ext_out(o_dq_out)
  );

  // command strobe passes untouched
  assign o_cmd_valid_int = i_cmd_valid;
  assign o_mirrored = mirrored_ff;
  assign o_mode_locked = locked_ff;
  assign o_sequential_init = seq_init_ff;
  assign o_parallel_init = par_init_ff;
endmodule : dlm_mirror_cfg
`default_nettype wire

// >>> sim/dlm_host_model.sv
// host side model: a mirror-mounted part sees every byte bit-reversed
`timescale 1ns/1ps
`default_nettype none
module dlm_host_model (
  input wire logic i_mount,
  input wire logic [7:0] i_byte,
  output logic [7:0] o_dq
);
  logic [7:0] flipped;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      flipped[k] = i_byte[7 - k];
    end
  end
  // a mirror-mounted host byte lands on the opposite lanes
  assign o_dq = i_mount ? flipped : i_byte;
endmodule : dlm_host_model
`default_nettype wire

// >>> sim/dlm_mirror_cfg_monitor.sv
// assertions on the lane mirror block ports
`timescale 1ns/1ps
`default_nettype none
module dlm_mirror_cfg_monitor (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_cmd_valid,
  input wire logic i_pin_reduction_en,
  input wire logic [7:0] i_dq_in,
  input wire logic [7:0] i_dq_out_int,
  input wire logic [7:0] o_dq_in_int,
  input wire logic [7:0] o_dq_out,
  input wire logic o_cmd_valid_int,
  input wire logic o_mirrored,
  input wire logic o_mode_locked,
  input wire logic o_sequential_init,
  input wire logic o_parallel_init
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic f;
  logic st;
  logic reset_seen_ff;
  logic [7:0] rev_in;
  logic [7:0] rev_out;
  assign f = i_cmd_valid && !o_mode_locked;
  assign st = i_cmd_valid && (i_dq_in == 8'h70 || i_dq_in == 8'h0E);
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      rev_in[k] = i_dq_in[7 - k];
      rev_out[k] = i_dq_out_int[7 - k];
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      reset_seen_ff <= 1'b0;
    end else if (i_cmd_valid && o_dq_in_int == 8'hFF) begin
      reset_seen_ff <= 1'b1;
    end
  end
  lane_in_a: assert property (o_dq_in_int == (o_mirrored ? rev_in : i_dq_in))
    else $error("in map");
  lane_out_a: assert property (o_dq_out == (o_mirrored ? rev_out : i_dq_out_int))
    else $error("out map");
  valid_pass_a: assert property (o_cmd_valid_int == i_cmd_valid) else $error("valid");
  first_mir_a: assert property (f && i_dq_in == 8'h0E |=> o_mirrored && o_mode_locked)
    else $error("mirror");
  first_norm_a: assert property (f && i_dq_in != 8'h0E |=> !o_mirrored && o_mode_locked)
    else $error("normal");
  mode_hold_a: assert property (o_mode_locked |=> o_mode_locked && $stable(o_mirrored))
    else $error("hold");
  unset_norm_a: assert property (!o_mode_locked |-> !o_mirrored) else $error("unset");
  seq_init_a: assert property (st && !reset_seen_ff && i_pin_reduction_en && !o_sequential_init
    && !o_parallel_init |=> o_sequential_init && !o_parallel_init)
    else $error("seq");
  par_init_a: assert property (st && reset_seen_ff && i_pin_reduction_en && !o_sequential_init
    && !o_parallel_init |=> o_parallel_init && !o_sequential_init)
    else $error("par");
  init_one_a: assert property (!(o_sequential_init && o_parallel_init)) else $error("both");
  init_hold_a: assert property (o_sequential_init || o_parallel_init
    |=> $stable({o_sequential_init, o_parallel_init}))
    else $error("init hold");
  init_off_a: assert property (!i_pin_reduction_en && !o_sequential_init && !o_parallel_init
    |=> !o_sequential_init && !o_parallel_init)
    else $error("init off");
  c_mir: cover property (f ##1 o_mirrored);
  c_seq: cover property ($rose(o_sequential_init));
  c_par: cover property ($rose(o_parallel_init));
  c_hard: cover property (o_mirrored && i_cmd_valid && o_dq_in_int == 8'hFD);
endmodule : dlm_mirror_cfg_monitor
bind dlm_mirror_cfg dlm_mirror_cfg_monitor mon (
  .i_clock(i_clock),
  .i_srst(i_srst),
  .i_cmd_valid(i_cmd_valid),
  .i_pin_reduction_en(i_pin_reduction_en),
  .i_dq_in(i_dq_in),
  .i_dq_out_int(i_dq_out_int),
  .o_dq_in_int(o_dq_in_int),
  .o_dq_out(o_dq_out),
  .o_cmd_valid_int(o_cmd_valid_int),
  .o_mirrored(o_mirrored),
  .o_mode_locked(o_mode_locked),
  .o_sequential_init(o_sequential_init),
  .o_parallel_init(o_parallel_init)
);
`default_nettype wire

// >>> sim/dlm_mirror_cfg_bench.sv
// bench for the lane mirror block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module dlm_mirror_cfg_bench;
  logic i_clock = 0, i_srst = 1, i_cmd_valid = 0, i_pin_reduction_en = 1, mount = 0;
  logic [7:0] i_dq_in, o_dq_in_int, o_dq_out, i_dq_out_int = 8'h01, bv = 8'h00;
  logic o_cmd_valid_int, o_mirrored, o_mode_locked, o_sequential_init, o_parallel_init;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #25 i_clock = ~i_clock;
  dlm_host_model host (.i_mount(mount), .i_byte(bv), .o_dq(i_dq_in));
  dlm_mirror_cfg uut (.i_clock, .i_srst, .i_cmd_valid, .i_dq_in, .i_dq_out_int,
    .i_pin_reduction_en, .o_dq_in_int, .o_dq_out, .o_cmd_valid_int, .o_mirrored,
    .o_mode_locked, .o_sequential_init, .o_parallel_init);
  task automatic do_reset(input logic m, input logic pr);
    mount = m;
    i_pin_reduction_en = pr;
    i_srst = 1;
    repeat (4) @(negedge i_clock);
    i_srst = 0;
  endtask : do_reset
  task automatic send(input logic [7:0] b);
    bv = b;
    i_cmd_valid = 1;
    #5 `CHK(o_cmd_valid_int, 1'b1)
    @(negedge i_clock) i_cmd_valid = 0;
    @(negedge i_clock);
  endtask : send
  task automatic test_normal;
    do_reset(0, 1);
    `CHK(o_mirrored, 1'b0)
    send(8'hFF);
    `CHK({o_mirrored, o_mode_locked}, 2'b01)
    send(8'h70);
    `CHK({o_mirrored, o_mode_locked}, 2'b01)
    `CHK({o_sequential_init, o_parallel_init}, 2'b01)
    `CHK({o_dq_in_int, o_dq_out}, 16'h7001)
  endtask : test_normal
  task automatic test_mirror;
    do_reset(1, 1);
    send(8'h70);
    `CHK({o_mirrored, o_sequential_init, o_parallel_init}, 3'b110)
    `CHK({o_dq_in_int, o_dq_out}, 16'h7080)
    send(8'hFD);
    `CHK(o_mirrored, 1'b1)
    send(8'hFF);
    send(8'h70);
    `CHK({o_mirrored, o_sequential_init, o_parallel_init}, 3'b110)
  endtask : test_mirror
  task automatic test_refuse;
    do_reset(0, 0);
    send(8'h70);
    `CHK({o_mode_locked, o_sequential_init, o_parallel_init}, 3'b100)
    send(8'h0E);
    `CHK({o_mirrored, o_mode_locked}, 2'b01)
    `CHK({o_dq_in_int, o_dq_out}, 16'h0E01)
  endtask : test_refuse
  task automatic test_late;
    do_reset(1, 1);
    send(8'hFF);
    send(8'h70);
    `CHK({o_mirrored, o_sequential_init, o_parallel_init}, 3'b001)
    `CHK(o_dq_in_int, 8'h0E)
  endtask : test_late
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  always @(posedge i_clock) if (++cyc > 200) begin n_fail++; complete_run(); end
  initial begin test_normal(); test_mirror(); test_refuse(); test_late(); complete_run(); end
endmodule : dlm_mirror_cfg_bench
`default_nettype wire
